/* cmb_memory.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"
module cmb_memory (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // base address strap
   input wire logic [`CMB_SYS_ADDR_W-1:0] base_addr_i,
   // bus
   cmb_bus_if.memory bus,
   // status
   output logic busy_o
);
   cmb_pkg::cmb_state_t state_q;
   logic [`CMB_CNT_W-1:0] cnt_q;
   logic [`CMB_DATA_W-1:0] mem_q [0:`CMB_WORDS-1];
   logic [`CMB_DATA_W-1:0] mdr_q;
   logic [`CMB_DATA_W-1:0] wlatch_q;
   logic [`CMB_NBYTES-1:0] sel_q;
   logic [`CMB_ADDR_W-1:0] waddr_q;
   logic [1:0] op_q;
   logic [`CMB_SYS_ADDR_W-1:0] off;
   logic hit;
   logic [`CMB_DATA_W-1:0] merged;
   logic [`CMB_DATA_W-1:0] rdata_q;
   logic rvalid_q;
   logic done_q;
   logic sense_now;
   logic restore_now;
   logic access_end;
   logic cycle_end;

   ////////////////////////////////////////////////////////////////////
   // one word is four 9-bit bytes; byte i sits at bits 9i+8 down to 9i,
   // and bit 8 of each byte travels as plain data, since parity belongs
   // to the master and the memory neither makes nor checks it
   //
   // timeline of one cycle, in clocks from the edge that takes the request:
   //   edge 0          sequencer leaves idle with the request latched
   //   edge 1          word sensed into the data register, core cleared
   //   edge ACCESS-1   sequencer moves on to restore
   //   edge ACCESS     merged word written back, read data raised
   //   edge CYCLE-1    sequencer reaches done
   //   edge CYCLE      done raised, held until the master lets go
   // between edge 1 and edge ACCESS the addressed word lives only in the
   // data register, so a reset in that span loses it; hold reset off
   // while busy is high

   ////////////////////////////////////////////////////////////////////
   // operation decode, shared by the sequencer, merge and answer logic
   // the one code the bus leaves unused
   function automatic logic op_unused(input logic [1:0] op);
      op_unused = (op == 2'(cmb_pkg::CMB_OP_NONE));
   endfunction

   // cycles that hand the old word back to the master
   function automatic logic op_returns(input logic [1:0] op);
      op_returns = (op == 2'(cmb_pkg::CMB_OP_READ)) || (op == 2'(cmb_pkg::CMB_OP_XCHG));
   endfunction

   // cycles that store master bytes into the selected lanes
   function automatic logic op_stores(input logic [1:0] op);
      op_stores = (op == 2'(cmb_pkg::CMB_OP_WRITE)) || (op == 2'(cmb_pkg::CMB_OP_XCHG));
   endfunction

   ////////////////////////////////////////////////////////////////////
   // single-edge strobes of the sequence
   assign access_end = (cnt_q == `CMB_CNT_W'(`CMB_ACCESS_CYC - 2)); // RULE_17
   assign cycle_end = (cnt_q == `CMB_CNT_W'(`CMB_CYCLE_CYC - 2)); // RULE_18
   assign sense_now = (state_q == cmb_pkg::CMB_ACCESS) && (cnt_q == '0);
   assign restore_now = (state_q == cmb_pkg::CMB_RESTORE)
      && (cnt_q == `CMB_CNT_W'(`CMB_ACCESS_CYC - 1));

   ////////////////////////////////////////////////////////////////////
   // address decode against the base
   assign off = bus.addr - base_addr_i;
   assign hit = (bus.addr >= base_addr_i) && (off < `CMB_SYS_ADDR_W'(`CMB_WORDS)); // RULE_20

   // merge: selected bytes from the write latch, others restored from the data register;
   // a read keeps every byte whatever the selects show
   for (genvar g = 0; g < `CMB_NBYTES; g++) begin : g_merge
      assign merged[g*`CMB_BYTE_W +: `CMB_BYTE_W] = (op_stores(op_q) && sel_q[g])
         ? wlatch_q[g*`CMB_BYTE_W +: `CMB_BYTE_W] // RULE_11 RULE_14
         : mdr_q[g*`CMB_BYTE_W +: `CMB_BYTE_W]; // RULE_12 RULE_15 RULE_07
   end

   ////////////////////////////////////////////////////////////////////
   // cycle sequencer, starts only on a master request
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_q <= cmb_pkg::CMB_IDLE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            cmb_pkg::CMB_IDLE: begin
               cnt_q <= '0;
               if (bus.req && hit && !op_unused({bus.op_code_high, bus.op_code_low})) begin
                  state_q <= cmb_pkg::CMB_ACCESS; // RULE_05 RULE_01
               end
            end
            cmb_pkg::CMB_ACCESS: begin
               cnt_q <= cnt_q + 1'b1;
               if (access_end) begin
                  state_q <= cmb_pkg::CMB_RESTORE; // RULE_17
               end
            end
            cmb_pkg::CMB_RESTORE: begin
               cnt_q <= cnt_q + 1'b1;
               if (cycle_end) begin
                  state_q <= cmb_pkg::CMB_DONE; // RULE_18
               end
            end
            cmb_pkg::CMB_DONE: begin
               if (!bus.req) begin
                  state_q <= cmb_pkg::CMB_IDLE; // RULE_21
               end
            end
            default: state_q <= cmb_pkg::CMB_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // request capture and write-data latch
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wlatch_q <= '0;
         sel_q <= '0;
         waddr_q <= '0;
         op_q <= 2'b00;
      end else if (state_q == cmb_pkg::CMB_IDLE) begin
         wlatch_q <= bus.wdata; // RULE_14 RULE_04
         sel_q <= bus.byte_sel;
         waddr_q <= off[`CMB_ADDR_W-1:0]; // RULE_19
         op_q <= {bus.op_code_high, bus.op_code_low};
      end
   end

   // destructive read into data register, then restore or store
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mdr_q <= '0;
      end else if (sense_now) begin
         mdr_q <= mem_q[waddr_q]; // RULE_08
      end
   end

   // core array: cleared at read, rewritten at end of access
   always_ff @(posedge clk_i) begin
      if (sense_now) begin
         mem_q[waddr_q] <= '0; // RULE_08
      end else if (restore_now) begin
         mem_q[waddr_q] <= merged; // RULE_09 RULE_11 RULE_15
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus answer registers, one process per flag so that no two
   // branches fight over the same register

   // read data: loaded once as the restore starts; a write hands back zeros
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_q <= '0;
      end else if (restore_now) begin
         rdata_q <= op_returns(op_q) ? mdr_q : '0; // RULE_07 RULE_13 RULE_02
      end
   end

   // read data valid from the restore until the master drops its request
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rvalid_q <= 1'b0;
      end else if (state_q == cmb_pkg::CMB_IDLE || !bus.req) begin
         rvalid_q <= 1'b0;
      end else if (restore_now) begin
         rvalid_q <= op_returns(op_q); // RULE_08 RULE_21
      end
   end

   // done raised once the restore is over, dropped when the request goes
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         done_q <= 1'b0;
      end else if (state_q == cmb_pkg::CMB_DONE && bus.req) begin
         done_q <= 1'b1; // RULE_21
      end else begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= (state_q != cmb_pkg::CMB_IDLE);
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.rvalid = rvalid_q;
   assign bus.done = done_q;
endmodule
`default_nettype wire

/* cmb_defs.svh */
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH
// Summary of operation
// RULE_01: op 00 read, 10 write, 11 exchange
// RULE_02: each cycle moves one 36-bit word
// RULE_03: master treats byte bit 8 as parity
// RULE_04: bit 9 of bytes 3,1 carried normally
// RULE_05: single master starts every transfer
// RULE_06: master drives address and operation code
// RULE_07: read returns all four bytes always
// RULE_08: read destructively into data register, drive bus
// RULE_09: read restores register into same location
// RULE_10: master gives byte selects on writes
// RULE_11: write latches, clears selected, stores latched
// RULE_12: write restores unselected bytes unchanged
// RULE_13: exchange returns old word, stores selected
// RULE_14: exchange latches write bytes during read
// RULE_15: exchange restores unselected bytes unchanged
// RULE_16: exchange write data precedes read data
// RULE_17: read data valid 600 to 800 ns
// RULE_18: full cycle 850 to 1150 ns
// RULE_19: word address is 14 bits
// RULE_20: respond only at or above base address
// RULE_21: memory flags data valid and done
`define CMB_CLK_NS 10
`define CMB_ACCESS_NS 750
`define CMB_CYCLE_NS 1080
`define CMB_ACCESS_CYC ((`CMB_ACCESS_NS + `CMB_CLK_NS - 1) / `CMB_CLK_NS)
`define CMB_CYCLE_CYC ((`CMB_CYCLE_NS + `CMB_CLK_NS - 1) / `CMB_CLK_NS)
`define CMB_CNT_W 8
`define CMB_ADDR_W 14
`define CMB_SYS_ADDR_W 17
`define CMB_DATA_W 36
`define CMB_BYTE_W 9
`define CMB_NBYTES 4
`define CMB_WORDS 16384
`define CMB_BASE_DEF 17'h00000
`endif

/* cmb_pkg.sv */
package cmb_pkg;
   typedef enum logic [1:0] {
      CMB_OP_READ = 2'b00,
      CMB_OP_NONE = 2'b01,
      CMB_OP_WRITE = 2'b10,
      CMB_OP_XCHG = 2'b11
   } cmb_op_t;
   typedef enum logic [1:0] {
      CMB_IDLE = 2'b00,
      CMB_ACCESS = 2'b01,
      CMB_RESTORE = 2'b10,
      CMB_DONE = 2'b11
   } cmb_state_t;
endpackage

/* cmb_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"
interface cmb_bus_if;
   logic req;
   logic [`CMB_SYS_ADDR_W-1:0] addr;
   logic op_code_low;
   logic op_code_high;
   logic [`CMB_NBYTES-1:0] byte_sel;
   logic [`CMB_DATA_W-1:0] wdata;
   logic [`CMB_DATA_W-1:0] rdata;
   logic rvalid;
   logic done;
   modport master (output req, addr, op_code_low, op_code_high, byte_sel, wdata,
      input rdata, rvalid, done);
   modport memory (input req, addr, op_code_low, op_code_high, byte_sel, wdata,
      output rdata, rvalid, done);
endinterface
`default_nettype wire

/* cmb_master.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"
module cmb_master (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // user request
   input wire logic start_i,
   input wire logic [`CMB_SYS_ADDR_W-1:0] addr_i,
   input wire logic [1:0] op_i,
   input wire logic [`CMB_NBYTES-1:0] byte_sel_i,
   input wire logic [`CMB_DATA_W-1:0] wdata_i,
   // user answer
   output logic [`CMB_DATA_W-1:0] rdata_o,
   output logic done_o,
   output logic busy_o,
   // bus
   cmb_bus_if.master bus
);
   logic req_q;
   logic [`CMB_SYS_ADDR_W-1:0] addr_q;
   logic [1:0] op_q;
   logic [`CMB_NBYTES-1:0] sel_q;
   logic [`CMB_DATA_W-1:0] wdata_q;

   ////////////////////////////////////////////////////////////////////
   // request held until the memory signals done
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         req_q <= 1'b0;
         addr_q <= '0;
         op_q <= 2'b00;
         sel_q <= '0;
         wdata_q <= '0;
      end else if (!req_q) begin
         if (start_i && op_i != 2'(cmb_pkg::CMB_OP_NONE)) begin
            req_q <= 1'b1; // RULE_05 RULE_01
            addr_q <= addr_i; // RULE_06
            op_q <= op_i;
            sel_q <= byte_sel_i; // RULE_10
            wdata_q <= wdata_i; // RULE_16
         end
      end else if (bus.done) begin
         req_q <= 1'b0; // RULE_21
      end
   end

   // answer capture; parity bit 8 is passed through to the user
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= '0;
         done_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         done_o <= req_q && bus.done;
         busy_o <= req_q || start_i;
         if (req_q && bus.rvalid) begin
            rdata_o <= bus.rdata; // RULE_03
         end
      end
   end

   assign bus.req = req_q;
   assign bus.addr = addr_q;
   assign bus.op_code_low = op_q[0];
   assign bus.op_code_high = op_q[1];
   assign bus.byte_sel = sel_q;
   assign bus.wdata = wdata_q;
endmodule
`default_nettype wire

/* cmb_bus_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"
module cmb_bus_props (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // bus signals
   input wire logic req,
   input wire logic [`CMB_SYS_ADDR_W-1:0] addr,
   input wire logic op_code_low,
   input wire logic op_code_high,
   input wire logic [`CMB_NBYTES-1:0] byte_sel,
   input wire logic [`CMB_DATA_W-1:0] wdata,
   input wire logic [`CMB_DATA_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic done
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // request side
   req_held_a: assert property (req && !done |=> req)
      else $error("request dropped before done");
   req_stable_a: assert property (req && !done |=>
      $stable({addr, op_code_high, op_code_low, byte_sel, wdata}))
      else $error("request fields moved mid cycle");
   no_unused_op_a: assert property (req |-> !(!op_code_high && op_code_low))
      else $error("unused op code issued");
   ////////////////////////////////////////////////////////////////////////////////
   // answer side
   // 10 ns clock: read data within 600 to 800 ns of the request being seen
   access_time_a: assert property ($rose(req) && !(op_code_high && !op_code_low)
      |-> ##[60:80] rvalid)
      else $error("read data late");
   // whole cycle within 850 to 1150 ns
   cycle_time_a: assert property ($rose(req) |-> ##[85:115] done)
      else $error("cycle not complete in time");
   write_no_data_a: assert property (req && op_code_high && !op_code_low |-> !rvalid)
      else $error("data valid on write");
   done_has_data_a: assert property (done && !(op_code_high && !op_code_low) |-> rvalid)
      else $error("done before read data");
   rdata_held_a: assert property (rvalid && $past(rvalid) |-> $stable(rdata))
      else $error("read data moved while valid");
   release_idle_a: assert property ($fell(req) |-> ##1 !done && !rvalid)
      else $error("memory answers without request");
   ////////////////////////////////////////////////////////////////////////////////
   // main scenarios
   cover property (done && !op_code_high);
   cover property (done && op_code_high && !op_code_low);
   cover property (done && op_code_high && op_code_low);
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"
module testbench;
   typedef logic [`CMB_DATA_W-1:0] cmb_word_t;
   localparam logic [`CMB_SYS_ADDR_W-1:0] BASE = 17'h04000;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic start_i = 1'b0;
   logic [`CMB_SYS_ADDR_W-1:0] addr_i = '0;
   logic [1:0] op_i = 2'b00;
   logic [3:0] byte_sel_i = 4'h0;
   cmb_word_t wdata_i = '0;
   cmb_word_t rdata_o;
   logic done_o;
   logic mst_busy;
   logic mem_busy;
   cmb_word_t shadow [8];
   int bad_count = 0;
   int num_checks = 0;
   integer seed = 59;
   cmb_bus_if bus ();
   cmb_master cmb_master_i (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i), .addr_i(addr_i),
      .op_i(op_i), .byte_sel_i(byte_sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .done_o(done_o), .busy_o(mst_busy), .bus(bus.master));
   cmb_memory cmb_memory_i (.clk_i(clk_i), .nrst_i(nrst_i), .base_addr_i(BASE),
      .bus(bus.memory), .busy_o(mem_busy));
   cmb_bus_props cmb_bus_props_i (.clk_i(clk_i), .nrst_i(nrst_i), .req(bus.req),
      .addr(bus.addr), .op_code_low(bus.op_code_low), .op_code_high(bus.op_code_high),
      .byte_sel(bus.byte_sel), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid),
      .done(bus.done));
   ////////////////////////////////////////////////////////////////////////////////
   // clock
   always #5 clk_i = ~clk_i;
   // compare and count
   task automatic check(input cmb_word_t seen, input cmb_word_t exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // print counts and verdict, then stop
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // selected bytes take new data, others keep old
   function automatic cmb_word_t merge(input cmb_word_t old, input cmb_word_t nw,
      input logic [3:0] sel);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[9*b +: 9] = nw[9*b +: 9];
         end
      end
   endfunction
   // one bus cycle through the master, checked against the shadow copy
   task automatic run(input logic [1:0] op, input logic [2:0] wa, input logic [3:0] sel,
      input cmb_word_t wd);
      int n;
      @(posedge clk_i);
      start_i <= 1'b1;
      op_i <= op;
      addr_i <= BASE + 17'(wa);
      byte_sel_i <= sel;
      wdata_i <= wd;
      @(posedge clk_i);
      start_i <= 1'b0;
      n = 0;
      while (done_o !== 1'b1) begin
         @(posedge clk_i);
         #1;
         n++;
         if (n > 150) begin
            bad_count++;
            $display("BAD at %0t: cycle never completed", $time);
            give_verdict();
         end
      end
      check(36'(mem_busy), 36'h1);
      if (op != 2'b10) begin
         check(rdata_o, shadow[wa]);
         check(bus.rdata, shadow[wa]);
      end
      if (op[1]) begin
         shadow[wa] = merge(shadow[wa], wd, sel);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [1:0] op;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      // fill the eight test words so later reads are known
      for (int a = 0; a < 8; a++) begin
         run(2'b10, a[2:0], 4'hF, 36'({$random(seed), $random(seed)}));
      end
      // corner cases: empty selects, single bytes, back to back
      run(2'b10, 3'h0, 4'h0, 36'hF_FFFF_FFFF);
      run(2'b00, 3'h0, 4'h0, '0);
      run(2'b11, 3'h1, 4'hA, 36'hA_5A5A_5A5A);
      run(2'b11, 3'h1, 4'h0, '0);
      run(2'b10, 3'h7, 4'h8, 36'hF_F000_0000);
      run(2'b00, 3'h7, 4'h3, '0);
      // unused code must start nothing
      @(posedge clk_i);
      start_i <= 1'b1;
      op_i <= 2'b01;
      @(posedge clk_i);
      start_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      check(36'(bus.req), 36'h0);
      check(36'({mst_busy, mem_busy}), 36'h0);
      // word just past the top of the range is ignored; a mid-run reset frees the master
      @(posedge clk_i);
      start_i <= 1'b1;
      op_i <= 2'b00;
      addr_i <= BASE + 17'h04000;
      @(posedge clk_i);
      start_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      #1;
      check(36'({mem_busy, bus.done}), 36'h0);
      check(36'({mst_busy, bus.req}), 36'h3);
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      #1;
      check(36'({mst_busy, bus.req, done_o}), 36'h0);
      // random traffic on a few words
      for (int i = 0; i < 60; i++) begin
         op = 2'($random(seed));
         if (op == 2'b01) begin
            op = 2'b00;
         end
         run(op, 3'($random(seed)), 4'($random(seed)), 36'({$random(seed), $random(seed)}));
      end
      // read everything back
      for (int a = 0; a < 8; a++) begin
         run(2'b00, a[2:0], 4'h0, '0);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
